/* File: huf_dev_end.sv */
// Device end: transmit engine, receive buffer and flow control
// Notes on behaviour
// RL1: Start, data LSB first, optional parity, stop.
// RL2: Character timing error within -2.5% and +1.5%.
// RL3: Each bit within 12.5% of nominal.
// RL4: Device may transmit after clear-to-send falls.
// RL5: Clear-to-send high one bit; stop within character.
// RL6: Host sends after request-to-send falls.
// RL7: Request-to-send rises at quarter full; accept 16.
// RL8: Parity selectable; both ends configured alike.
`timescale 1ns/1ps

module huf_ser_tx #(
  parameter int DIV = 25,
  parameter int DATA_BITS = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic go,
  input wire logic par_en,
  input wire logic par_odd,
  input wire logic [DATA_BITS-1:0] data,
  input wire logic valid,
  output logic ready_ff,
  output logic line_ff
);
  import huf_pkg::*;
  localparam int CW = $clog2(DIV + 1);
  localparam int IW = $clog2(DATA_BITS + 1);
  huf_state_e st_ff, nxt_st;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic [IW-1:0] idx_ff, nxt_idx;
  logic [DATA_BITS-1:0] sh_ff, nxt_sh;
  logic par_ff, nxt_par, nxt_line, nxt_ready, tick;

  // Integer divider, so every bit lasts exactly DIV cycles
  assign tick = (cnt_ff == CW'(DIV - 1)); // see RL3

  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = tick ? '0 : cnt_ff + 1'b1;
    nxt_idx = idx_ff;
    nxt_sh = sh_ff;
    nxt_par = par_ff;
    nxt_line = line_ff;
    case (st_ff)
      HUF_IDLE: begin
        nxt_cnt = '0;
        nxt_line = LINE_IDLE;
        if (valid && ready_ff) begin // see RL4
          nxt_sh = data;
          nxt_par = par_odd;
          nxt_st = HUF_START;
          nxt_line = LINE_START; // see RL1
        end
      end
      HUF_START: if (tick) begin
        nxt_st = HUF_DATA;
        nxt_idx = '0;
        nxt_line = sh_ff[0];
      end
      HUF_DATA: if (tick) begin
        nxt_par = par_ff ^ sh_ff[0];
        nxt_sh = sh_ff >> 1;
        nxt_idx = idx_ff + 1'b1;
        if (idx_ff == IW'(DATA_BITS - 1)) begin
          nxt_st = par_en ? HUF_PAR : HUF_STOP; // see RL8
          nxt_line = par_en ? (par_ff ^ sh_ff[0]) : LINE_STOP;
        end else begin
          nxt_line = sh_ff[1]; // see RL1
        end
      end
      HUF_PAR: if (tick) begin
        nxt_st = HUF_STOP;
        nxt_line = LINE_STOP;
      end
      HUF_STOP: if (tick) nxt_st = HUF_IDLE;
      default: nxt_st = HUF_IDLE;
    endcase
    // Go is only looked at between characters, so a hold lets the current frame finish
    nxt_ready = (nxt_st == HUF_IDLE) && go; // see RL5
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_ff <= HUF_IDLE;
      cnt_ff <= '0;
      idx_ff <= '0;
      sh_ff <= '0;
      par_ff <= 1'b0;
      line_ff <= LINE_IDLE;
      ready_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      idx_ff <= nxt_idx;
      sh_ff <= nxt_sh;
      par_ff <= nxt_par;
      line_ff <= nxt_line;
      ready_ff <= nxt_ready;
    end
  end
endmodule // huf_ser_tx

module huf_dev_end #(
  parameter int BAUD = huf_pkg::BAUD_DEF,
  parameter int DATA_BITS = huf_pkg::DATA_BITS_DEF,
  parameter int RX_DEPTH = huf_pkg::RX_DEPTH_DEF
) (
  input wire logic clk,
  input wire logic sys_rst,
  huf_if.dev lnk,
  input wire logic par_en,
  input wire logic par_odd,
  input wire logic [DATA_BITS-1:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [DATA_BITS-1:0] rx_data_ff,
  output logic rx_valid_ff,
  input wire logic rx_ready,
  output logic rx_par_err,
  output logic rx_frm_err,
  output logic rx_overrun_ff
);
  import huf_pkg::*;
  localparam int DIV = (CLK_HZ + BAUD / 2) / BAUD;
  localparam longint ERR_PM =
    (longint'(CLK_HZ) * 1000) / (longint'(DIV) * BAUD) - 1000;
  localparam int AW = $clog2(RX_DEPTH);
  localparam int LW = $clog2(RX_DEPTH + 1);
  localparam int SW = $clog2(FLOW_START_CYC + 1);
  localparam int THRESH = RX_DEPTH / FILL_DIV;

  if (BAUD < BAUD_MIN || BAUD > BAUD_MAX || DIV < 4)
    $error("baud rate out of range");
  if (ERR_PM < CHAR_ERR_LO_PM || ERR_PM > CHAR_ERR_HI_PM) // see RL2
    $error("baud divider too coarse");
  if (DATA_BITS < 5 || DATA_BITS > 9)
    $error("data length unsupported");
  if (RX_DEPTH < 4 || (RX_DEPTH & (RX_DEPTH - 1)) != 0 ||
      RX_DEPTH - THRESH < DRAIN_CHARS + 1) // see RL7
    $error("receive buffer too small");

  logic [DATA_BITS-1:0] mem_ff [RX_DEPTH];
  logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
  logic [LW-1:0] lvl_ff, nxt_lvl;
  logic [SW-1:0] wait_ff, nxt_wait;
  logic [DATA_BITS-1:0] nxt_rx_data, ch_data;
  logic nxt_rx_valid, nxt_ovr, rts_n_ff, nxt_rts_n, go_ff, nxt_go;
  logic ch_valid, push, pop;

  huf_ser_tx #(.DIV(DIV), .DATA_BITS(DATA_BITS)) u_tx (
    .clk(clk),
    .sys_rst(sys_rst),
    .go(go_ff),
    .par_en(par_en),
    .par_odd(par_odd),
    .data(tx_data),
    .valid(tx_valid),
    .ready_ff(tx_ready),
    .line_ff(lnk.d2h_line)
  );

  huf_ser_rx #(.DIV(DIV), .DATA_BITS(DATA_BITS)) u_rx (
    .clk(clk),
    .sys_rst(sys_rst),
    .line(lnk.h2d_line),
    .par_en(par_en),
    .par_odd(par_odd),
    .data_ff(ch_data),
    .valid_ff(ch_valid),
    .par_err_ff(rx_par_err),
    .frm_err_ff(rx_frm_err)
  );

  assign lnk.rts_n = rts_n_ff;

  always_comb begin
    nxt_wait = wait_ff;
    if (lnk.cts_n == FLOW_HOLD) begin
      nxt_wait = '0;
    end else if (wait_ff != SW'(FLOW_START_CYC)) begin
      nxt_wait = wait_ff + 1'b1;
    end
    // Hold takes effect at once; go waits out the start delay
    nxt_go = (lnk.cts_n == FLOW_GO) &&
      (wait_ff == SW'(FLOW_START_CYC)); // see RL4
  end

  always_comb begin
    push = ch_valid && (lvl_ff != LW'(RX_DEPTH));
    pop = (lvl_ff != '0) && (!rx_valid_ff || rx_ready);
    nxt_wr = push ? wr_ff + 1'b1 : wr_ff;
    nxt_rd = pop ? rd_ff + 1'b1 : rd_ff;
    nxt_lvl = lvl_ff + LW'(push) - LW'(pop);
    nxt_rx_data = pop ? mem_ff[rd_ff] : rx_data_ff;
    nxt_rx_valid = pop || (rx_valid_ff && !rx_ready);
    // Overrun only when the host ignored the hold for too long
    nxt_ovr = ch_valid && (lvl_ff == LW'(RX_DEPTH));
    nxt_rts_n = (nxt_lvl >= LW'(THRESH)) ? FLOW_HOLD : FLOW_GO; // see RL7
  end

  always_ff @(posedge clk) begin
    if (push) mem_ff[wr_ff] <= ch_data;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_ff <= '0;
      rd_ff <= '0;
      lvl_ff <= '0;
      wait_ff <= '0;
      go_ff <= 1'b0;
      rts_n_ff <= FLOW_HOLD;
      rx_data_ff <= '0;
      rx_valid_ff <= 1'b0;
      rx_overrun_ff <= 1'b0;
    end else begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      lvl_ff <= nxt_lvl;
      wait_ff <= nxt_wait;
      go_ff <= nxt_go;
      rts_n_ff <= nxt_rts_n;
      rx_data_ff <= nxt_rx_data;
      rx_valid_ff <= nxt_rx_valid;
      rx_overrun_ff <= nxt_ovr;
    end
  end
endmodule // huf_dev_end

/* File: huf_host_end.sv */
// Host end, flow control and the receive engine both ends share
`timescale 1ns/1ps
module huf_ser_rx #(
  parameter int DIV = 25,
  parameter int DATA_BITS = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic line,
  input wire logic par_en,
  input wire logic par_odd,
  output logic [DATA_BITS-1:0] data_ff,
  output logic valid_ff,
  output logic par_err_ff,
  output logic frm_err_ff
);
  import huf_pkg::*;
  localparam int CW = $clog2(DIV + 1);
  localparam int IW = $clog2(DATA_BITS + 1);
  huf_state_e st_ff, nxt_st;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic [IW-1:0] idx_ff, nxt_idx;
  logic [DATA_BITS-1:0] nxt_data;
  logic par_ff, nxt_par, nxt_valid, nxt_perr, nxt_ferr, tick;

  assign tick = (cnt_ff == CW'(DIV - 1));

  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = tick ? '0 : cnt_ff + 1'b1;
    nxt_idx = idx_ff;
    nxt_data = data_ff;
    nxt_par = par_ff;
    nxt_valid = 1'b0;
    nxt_perr = par_err_ff;
    nxt_ferr = frm_err_ff;
    case (st_ff)
      HUF_IDLE: begin
        nxt_cnt = '0;
        if (line == LINE_START) nxt_st = HUF_START;
      end
      // Sampling at mid-bit leaves half a bit of margin for drift
      HUF_START: if (cnt_ff == CW'(DIV / 2 - 1)) begin // see RL3
        nxt_cnt = '0;
        nxt_idx = '0;
        nxt_par = par_odd;
        nxt_st = (line == LINE_START) ? HUF_DATA : HUF_IDLE;
      end
      HUF_DATA: if (tick) begin
        nxt_data = {line, data_ff[DATA_BITS-1:1]}; // see RL1
        nxt_par = par_ff ^ line;
        nxt_idx = idx_ff + 1'b1;
        if (idx_ff == IW'(DATA_BITS - 1))
          nxt_st = par_en ? HUF_PAR : HUF_STOP; // see RL8
      end
      HUF_PAR: if (tick) begin
        nxt_par = par_ff ^ line;
        nxt_st = HUF_STOP;
      end
      HUF_STOP: if (tick) begin
        nxt_valid = 1'b1;
        nxt_perr = par_en && nxt_par;
        nxt_ferr = (line != LINE_STOP);
        nxt_st = HUF_IDLE;
      end
      default: nxt_st = HUF_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_ff <= HUF_IDLE;
      cnt_ff <= '0;
      idx_ff <= '0;
      par_ff <= 1'b0;
      data_ff <= '0;
      valid_ff <= 1'b0;
      par_err_ff <= 1'b0;
      frm_err_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      idx_ff <= nxt_idx;
      par_ff <= nxt_par;
      data_ff <= nxt_data;
      valid_ff <= nxt_valid;
      par_err_ff <= nxt_perr;
      frm_err_ff <= nxt_ferr;
    end
  end
endmodule // huf_ser_rx

module huf_host_end #(
  parameter int BAUD = huf_pkg::BAUD_DEF,
  parameter int DATA_BITS = huf_pkg::DATA_BITS_DEF
) (
  input wire logic clk,
  input wire logic sys_rst,
  huf_if.host lnk,
  input wire logic par_en,
  input wire logic par_odd,
  input wire logic hold_req,
  input wire logic [DATA_BITS-1:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [DATA_BITS-1:0] rx_data,
  output logic rx_valid,
  output logic rx_par_err,
  output logic rx_frm_err
);
  import huf_pkg::*;
  localparam int DIV = (CLK_HZ + BAUD / 2) / BAUD;
  localparam int SW = $clog2(FLOW_START_CYC + 1);
  localparam int HW = $clog2(DIV + 1);

  if (BAUD < BAUD_MIN || BAUD > BAUD_MAX || DIV < 4)
    $error("baud rate out of range");
  if (DATA_BITS < 5 || DATA_BITS > 9)
    $error("data length unsupported");

  logic [SW-1:0] wait_ff, nxt_wait;
  logic [HW-1:0] hcnt_ff, nxt_hcnt;
  logic go_ff, nxt_go, cts_n_ff, nxt_cts_n;

  huf_ser_tx #(.DIV(DIV), .DATA_BITS(DATA_BITS)) u_tx (
    .clk(clk),
    .sys_rst(sys_rst),
    .go(go_ff),
    .par_en(par_en),
    .par_odd(par_odd),
    .data(tx_data),
    .valid(tx_valid),
    .ready_ff(tx_ready),
    .line_ff(lnk.h2d_line)
  );

  huf_ser_rx #(.DIV(DIV), .DATA_BITS(DATA_BITS)) u_rx (
    .clk(clk),
    .sys_rst(sys_rst),
    .line(lnk.d2h_line),
    .par_en(par_en),
    .par_odd(par_odd),
    .data_ff(rx_data),
    .valid_ff(rx_valid),
    .par_err_ff(rx_par_err),
    .frm_err_ff(rx_frm_err)
  );

  assign lnk.cts_n = cts_n_ff;

  always_comb begin
    nxt_wait = wait_ff;
    if (lnk.rts_n == FLOW_HOLD) begin
      nxt_wait = '0;
    end else if (wait_ff != SW'(FLOW_START_CYC)) begin
      nxt_wait = wait_ff + 1'b1;
    end
    // Stopping between characters keeps the overshoot to one
    nxt_go = (lnk.rts_n == FLOW_GO) &&
      (wait_ff == SW'(FLOW_START_CYC)); // see RL6
  end

  always_comb begin
    nxt_hcnt = hcnt_ff;
    nxt_cts_n = cts_n_ff;
    if (cts_n_ff == FLOW_HOLD && hcnt_ff != HW'(DIV)) begin
      nxt_hcnt = hcnt_ff + 1'b1;
    end else if (hold_req) begin
      nxt_cts_n = FLOW_HOLD;
      if (cts_n_ff == FLOW_GO) nxt_hcnt = '0;
    end else begin
      // Release only after a full bit time of hold
      nxt_cts_n = FLOW_GO; // see RL5
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wait_ff <= '0;
      go_ff <= 1'b0;
      hcnt_ff <= '0;
      cts_n_ff <= FLOW_HOLD;
    end else begin
      wait_ff <= nxt_wait;
      go_ff <= nxt_go;
      hcnt_ff <= nxt_hcnt;
      cts_n_ff <= nxt_cts_n;
    end
  end
endmodule // huf_host_end

/* File: huf_if.sv */
// Serial lines and flow-control lines joining the device and host ends
`timescale 1ns/1ps
interface huf_if;
  logic d2h_line;
  logic h2d_line;
  logic cts_n;
  logic rts_n;
  modport dev (output d2h_line, output rts_n, input h2d_line, input cts_n);
  modport host (input d2h_line, input rts_n, output h2d_line,
    output cts_n);
endinterface

/* File: huf_link_monitor.sv */
// Protocol checker for the serial and flow-control lines
`timescale 1ns/1ps
module huf_link_monitor (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic d2h_line,
  input wire logic h2d_line,
  input wire logic cts_n,
  input wire logic rts_n
);
  import huf_pkg::*;
  // Start gate is at least the full flow delay, two cycles back
  localparam logic [9:0] START_MIN = 10'(FLOW_START_CYC);
  // One character at the default rate plus a little margin
  localparam logic [9:0] STOP_LIM = 10'h012c;
  logic [9:0] cts_lo_ff, rts_lo_ff, cts_hi_ff, rts_hi_ff;
  logic [9:0] nxt_cts_lo, nxt_rts_lo, nxt_cts_hi, nxt_rts_hi;
  // Saturating, so long idle spans never wrap
  function automatic logic [9:0] sat(input logic [9:0] v);
    return (&v) ? v : v + 10'h1;
  endfunction
  always_comb begin
    nxt_cts_lo = cts_n ? 10'h0 : sat(cts_lo_ff);
    nxt_rts_lo = rts_n ? 10'h0 : sat(rts_lo_ff);
    nxt_cts_hi = cts_n ? sat(cts_hi_ff) : 10'h0;
    nxt_rts_hi = rts_n ? sat(rts_hi_ff) : 10'h0;
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cts_lo_ff <= 10'h0;
      rts_lo_ff <= 10'h0;
      cts_hi_ff <= 10'h0;
      rts_hi_ff <= 10'h0;
    end else begin
      cts_lo_ff <= nxt_cts_lo;
      rts_lo_ff <= nxt_rts_lo;
      cts_hi_ff <= nxt_cts_hi;
      rts_hi_ff <= nxt_rts_hi;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_lines_idle:
    assert property ($fell(sys_rst) |-> d2h_line && h2d_line && rts_n)
    else $error("lines not idle after reset");
  a_dev_bit_min:
    assert property ($changed(d2h_line) |=> $stable(d2h_line) [*8])
    else $error("device bit too short");
  a_host_bit_min:
    assert property ($changed(h2d_line) |=> $stable(h2d_line) [*8])
    else $error("host bit too short");
  a_cts_pulse:
    assert property ($rose(cts_n) |=> cts_n [*8])
    else $error("clear-to-send high too short");
  a_dev_start_wait:
    assert property ($fell(d2h_line) |-> $past(cts_lo_ff, 2) >= START_MIN)
    else $error("device sent before flow delay");
  a_host_start_wait:
    assert property ($fell(h2d_line) |-> $past(rts_lo_ff, 2) >= START_MIN)
    else $error("host sent before flow delay");
  a_dev_stops:
    assert property (cts_hi_ff > STOP_LIM |-> d2h_line)
    else $error("device kept sending while held");
  a_host_stops:
    assert property (rts_hi_ff > STOP_LIM |-> h2d_line)
    else $error("host kept sending while held");
  c_dev_char: cover property ($fell(d2h_line));
  c_host_char: cover property ($fell(h2d_line));
  c_rts_hold: cover property ($rose(rts_n));
  c_cts_hold: cover property ($rose(cts_n));
endmodule // huf_link_monitor

/* File: huf_pkg.sv */
// Shared constants and types for the host serial link with flow control
package huf_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int BAUD_MIN = 37_500;
  localparam int BAUD_MAX = 4_000_000;
  localparam int BAUD_DEF = 4_000_000;
  localparam int CHAR_ERR_LO_PM = -25;
  localparam int CHAR_ERR_HI_PM = 15;
  localparam int BIT_ERR_PM = 125;
  localparam int FLOW_START_NS = 2000;
  localparam int FLOW_START_CYC =
    (FLOW_START_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int DRAIN_CHARS = 16;
  localparam int FILL_DIV = 4;
  localparam int DATA_BITS_DEF = 8;
  localparam int RX_DEPTH_DEF = 64;
  localparam logic LINE_IDLE = 1'b1;
  localparam logic LINE_START = 1'b0;
  localparam logic LINE_STOP = 1'b1;
  localparam logic FLOW_GO = 1'b0;
  localparam logic FLOW_HOLD = 1'b1;
  typedef enum logic [2:0] {
    HUF_IDLE = 3'h0,
    HUF_START = 3'h1,
    HUF_DATA = 3'h3,
    HUF_PAR = 3'h2,
    HUF_STOP = 3'h6
  } huf_state_e;
endpackage

/* File: huf_tb.sv */
// Testbench joining device and host ends with a queue-based model
`timescale 1ns/1ps
module tb;
  import huf_pkg::*;
  logic clk, sys_rst, par_en, par_odd, hold_req, rx_rdy;
  logic [7:0] d_txd, d_rxd, h_txd, h_rxd, w;
  logic d_txv, d_rdy, d_rxv, d_perr, d_ferr, d_ovr;
  logic h_txv, h_rdy, h_rxv, h_perr, h_ferr;
  logic [7:0] dq[$], hq[$], wq[$];
  int n_mismatch = 0;
  int n_compared = 0;
  int m;
  huf_if lnk_if();
  huf_dev_end u_huf_dev_end (.clk(clk), .sys_rst(sys_rst), .lnk(lnk_if),
    .par_en(par_en), .par_odd(par_odd), .tx_data(d_txd),
    .tx_valid(d_txv), .tx_ready(d_rdy), .rx_data_ff(d_rxd),
    .rx_valid_ff(d_rxv), .rx_ready(rx_rdy), .rx_par_err(d_perr),
    .rx_frm_err(d_ferr), .rx_overrun_ff(d_ovr));
  huf_host_end u_huf_host_end (.clk(clk), .sys_rst(sys_rst),
    .lnk(lnk_if), .par_en(par_en), .par_odd(par_odd),
    .hold_req(hold_req), .tx_data(h_txd), .tx_valid(h_txv),
    .tx_ready(h_rdy), .rx_data(h_rxd), .rx_valid(h_rxv),
    .rx_par_err(h_perr), .rx_frm_err(h_ferr));
  huf_link_monitor u_huf_link_monitor (.clk(clk), .sys_rst(sys_rst),
    .d2h_line(lnk_if.d2h_line), .h2d_line(lnk_if.h2d_line),
    .cts_n(lnk_if.cts_n), .rts_n(lnk_if.rts_n));

  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic report_and_stop;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Holds valid until taken; bound only guards a stuck handshake
  task automatic send(input bit h, input logic [7:0] b);
    int t;
    @(negedge clk);
    if (h) begin
      h_txd = b;
      h_txv = 1;
      hq.push_back(b);
    end else begin
      d_txd = b;
      d_txv = 1;
      dq.push_back(b);
      wq.push_back(b);
    end
    // Ready is looked at mid-cycle, where it has settled
    t = 0;
    while (!(h ? h_rdy : d_rdy) && t < 5000) begin
      @(negedge clk);
      t++;
    end
    @(negedge clk);
    if (h) h_txv = 0;
    else d_txv = 0;
  endtask

  always @(posedge clk) begin
    if (!sys_rst && h_rxv) begin
      chk(h_rxd, dq.pop_front());
      chk({h_perr, h_ferr}, 8'h00);
    end
    if (!sys_rst && d_rxv && rx_rdy) chk(d_rxd, hq.pop_front());
    if (d_ovr) chk(d_ovr, 8'h00);
    if (d_perr | d_ferr) chk({d_perr, d_ferr}, 8'h00);
  end

  // Samples the device line mid-bit, independent of the host receiver
  always begin
    @(negedge lnk_if.d2h_line);
    repeat (12) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (25) @(posedge clk);
      w[i] = lnk_if.d2h_line;
    end
    if (par_en) begin
      repeat (25) @(posedge clk);
      chk(lnk_if.d2h_line, ^w ^ par_odd);
    end
    repeat (25) @(posedge clk);
    chk(lnk_if.d2h_line, LINE_STOP);
    chk(w, wq.pop_front());
  end

  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    report_and_stop;
  end

  initial begin
    sys_rst = 1;
    par_en = 0;
    par_odd = 0;
    hold_req = 0;
    rx_rdy = 1;
    d_txd = 8'h00;
    h_txd = 8'h00;
    d_txv = 0;
    h_txv = 0;
    repeat (5) @(negedge clk);
    sys_rst = 0;
    void'($urandom(34));
    for (m = 0; m < 3; m++) begin
      par_en = (m > 0);
      par_odd = (m == 2);
      fork
        repeat (4) send(0, 8'($urandom));
        repeat (4) send(1, 8'($urandom));
      join
      idle(600);
      $display("parity mode %0d done", m);
    end
    // Buffer backs up to the threshold, then drains
    rx_rdy = 0;
    fork
      repeat (20) send(1, 8'($urandom));
      begin
        idle(6000);
        chk(lnk_if.rts_n, FLOW_HOLD);
        rx_rdy = 1;
      end
    join
    idle(800);
    $display("receive flow test done");
    hold_req = 1;
    idle(5);
    fork
      send(0, 8'($urandom));
      begin
        idle(600);
        chk(lnk_if.cts_n, FLOW_HOLD);
        chk(8'(dq.size()), 8'h01);
        hold_req = 0;
      end
    join
    idle(800);
    chk(8'(dq.size() + hq.size()), 8'h00);
    $display("transmit hold test done");
    report_and_stop;
  end
endmodule // tb
